// ==== design/pll_prog_consts.vh ====
// Constants of the serial divider programmer and its register map
// Assumes inclusion by bare name from files under design/
`ifndef PLL_PROG_CONSTS_VH
`define PLL_PROG_CONSTS_VH

// Field widths
`define REF_W        14
`define DIV_W        17
`define SWAL_W       7
`define MAIN_W       10
`define SHIFT_W      18
`define DATA_W       32
`define ADR_W        5
`define SEL_W        4

// Field positions inside the shift register
`define CTL_BIT      0
`define REF_LSB      1
`define REF_MSB      14
`define DIV_LSB      1
`define DIV_MSB      17

// Field positions inside the divider latch
`define SWAL_LSB     0
`define SWAL_MSB     6
`define MAIN_LSB     7
`define MAIN_MSB     16

// Register byte offsets
`define OFF_CTRL     5'h00
`define OFF_STATUS   5'h04
`define OFF_REFLAT   5'h08
`define OFF_DIVLAT   5'h0C
`define OFF_SHIFT    5'h10

// Control and status bit positions
`define CTRL_RUN     0
`define ST_LOCK      0
`define ST_UP        1
`define ST_DOWN      2
`define ST_MOD       3
`define ST_CTL       4
`define ST_W         5

// Reset values
`define CTRL_RST     1'h1
`define REF_RST      14'h0000
`define DIV_RST      17'h00000
`define SHIFT_RST    18'h00000

// Input synchroniser lanes
`define PIN_N        4
`define PIN_SCLK     0
`define PIN_SDAT     1
`define PIN_XTAL     2
`define PIN_FB       3

`endif

// ==== design/pin_sync_edge.v ====
// Two-stage synchronisers with rise and fall detection for several pins
// Assumes asynchronous pin inputs and a single system clock
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge #(
   parameter W = 4
) (
   // System
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // Pins
   input  wire [W-1:0] pin_i,
   // Synchronised view
   output wire [W-1:0] level_o,
   output wire [W-1:0] rise_o,
   output wire [W-1:0] fall_o
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : lane
         reg meta;
         reg sync;
         reg last;
         always @(posedge clk_i) begin
            if (rst_i) begin
               meta <= 1'b0;
               sync <= 1'b0;
               last <= 1'b0;
            end else if (ce_i) begin
               meta <= pin_i[g];
               sync <= meta;
               last <= sync;
            end
         end
         assign level_o[g] = sync;
         assign rise_o[g]  = sync & ~last;
         assign fall_o[g]  = ~sync & last;
      end
   endgenerate
endmodule
`default_nettype wire

// ==== design/prog_down_counter.v ====
// Loadable down counter stepped by a tick, with last-count flags
// Assumes tick and reload come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module prog_down_counter #(
   parameter W = 10
) (
   // System
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // Control
   input  wire         tick_i,
   input  wire         reload_i,
   input  wire [W-1:0] value_i,
   // State
   output reg  [W-1:0] count_o,
   output wire         last_o,
   output wire         zero_o
);
   localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
   localparam [W-1:0] NONE = {W{1'b0}};

   assign last_o = (count_o <= ONE);
   assign zero_o = (count_o == NONE);

   always @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= NONE;
      end else if (ce_i && tick_i) begin
         if (reload_i) begin
            count_o <= value_i;
         end else if (!zero_o) begin
            count_o <= count_o - ONE;
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/serial_pll_divider_programmer.v ====
// Serial divider programmer, counters, modulus control and phase compare
// Assumes a classic Wishbone master and pins from outside the clock domain
//
// Function
// - Shift one data bit per serial clock rise
// - Control high: reference latch; low: divider latch
// - Strobe high transfers shift data into latch
// - Reference word: 14 data bits, control high
// - Divider word: 7 swallow, 10 main, control low
// - Swallow factor binary 0 to 127
// - Modulus output changes on feedback falling edge
// - Modulus high selects base, low selects plus one
// - Lock high when aligned, else low pulses
// - Reference divided output shows reference divider
// - Reference tap passes the oscillator frequency
// - Feedback divided output shows feedback divider
`include "pll_prog_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module serial_pll_divider_programmer (
   // System
   input  wire                  CLK_I,
   input  wire                  RST_I,
   input  wire                  CE_I,
   // Wishbone slave
   input  wire [`ADR_W-1:0]     ADR_I,
   input  wire [`DATA_W-1:0]    DAT_I,
   output reg  [`DATA_W-1:0]    DAT_O,
   input  wire [`SEL_W-1:0]     SEL_I,
   input  wire                  WE_I,
   input  wire                  CYC_I,
   input  wire                  STB_I,
   output reg                   ACK_O,
   // Serial programming pins
   input  wire                  SER_CLOCK_I,
   input  wire                  SER_DATA_I,
   input  wire                  LATCH_LOAD_STROBE_I,
   // Frequency inputs
   input  wire                  CRYSTAL_INPUT_I,
   input  wire                  FEEDBACK_IN_I,
   // Prescaler and monitor outputs
   output reg                   MOD_CONTROL_O,
   output reg                   REF_DIVIDED_OUT_O,
   output reg                   FEEDBACK_DIVIDED_OUT_O,
   output reg                   REFERENCE_CLOCK_TAP_O,
   output reg                   LOCK_DETECT_O,
   output reg                   PHASE_UP_O,
   output reg                   PHASE_DOWN_O
);

   // Address decode shared by the read and write paths
   function addr_hit;
      input [`ADR_W-1:0] adr;
      input [`ADR_W-1:0] off;
      begin
         addr_hit = (adr == off);
      end
   endfunction

   // Synchronised pins
   wire [`PIN_N-1:0]   pin_raw;
   wire [`PIN_N-1:0]   pin_level;
   wire [`PIN_N-1:0]   pin_rise;
   wire [`PIN_N-1:0]   pin_fall;
   reg                 strobe_meta;
   reg                 strobe_sync;

   // Programming state
   reg  [`SHIFT_W-1:0] shift_reg;
   reg  [`REF_W-1:0]   ref_latch;
   reg  [`DIV_W-1:0]   div_latch;
   reg                 run;

   // Counter wiring
   wire [`REF_W-1:0]   ref_count;
   wire                ref_last;
   wire [`MAIN_W-1:0]  main_count;
   wire                main_last;
   wire [`SWAL_W-1:0]  swal_count;
   wire                swal_last;
   wire                swal_zero;
   wire [`SWAL_W-1:0]  swal_value;
   wire [`MAIN_W-1:0]  main_value;
   wire                xtal_tick;
   wire                fb_tick;
   wire                ref_event;
   wire                fb_event;
   reg                 next_mod;

   // Bus wiring
   wire                bus_req;
   wire                bus_wr;
   wire [`ST_W-1:0]    status;
   reg  [`DATA_W-1:0]  next_dat;

   assign pin_raw[`PIN_SCLK] = SER_CLOCK_I;
   assign pin_raw[`PIN_SDAT] = SER_DATA_I;
   assign pin_raw[`PIN_XTAL] = CRYSTAL_INPUT_I;
   assign pin_raw[`PIN_FB]   = FEEDBACK_IN_I;

   pin_sync_edge #(
      .W (`PIN_N)
   ) u_sync (
      .clk_i   (CLK_I),
      .rst_i   (RST_I),
      .ce_i    (CE_I),
      .pin_i   (pin_raw),
      .level_o (pin_level),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // Load strobe synchroniser, reset high as the pin idles pulled up
   always @(posedge CLK_I) begin
      if (RST_I) begin
         strobe_meta <= 1'b1;
         strobe_sync <= 1'b1;
      end else if (CE_I) begin
         strobe_meta <= LATCH_LOAD_STROBE_I;
         strobe_sync <= strobe_meta;
      end
   end

   // Serial shift register; the control bit ends up in the lowest place
   always @(posedge CLK_I) begin
      if (RST_I) begin
         shift_reg <= `SHIFT_RST;
      end else if (CE_I && pin_rise[`PIN_SCLK]) begin
         shift_reg <= {shift_reg[`SHIFT_W-2:0], pin_level[`PIN_SDAT]};
      end
   end

   // Latch transfer while the strobe stays high
   always @(posedge CLK_I) begin
      if (RST_I) begin
         ref_latch <= `REF_RST;
         div_latch <= `DIV_RST;
      end else if (CE_I && strobe_sync) begin
         if (shift_reg[`CTL_BIT]) begin
            ref_latch <= shift_reg[`REF_MSB:`REF_LSB];
         end else begin
            div_latch <= shift_reg[`DIV_MSB:`DIV_LSB];
         end
      end
   end

   // Split of the divider latch into its two factors
   assign swal_value = div_latch[`SWAL_MSB:`SWAL_LSB];
   assign main_value = div_latch[`MAIN_MSB:`MAIN_LSB];

   // Counters step only while running
   assign xtal_tick = run & pin_rise[`PIN_XTAL];
   assign fb_tick   = run & pin_fall[`PIN_FB];
   assign ref_event = xtal_tick & ref_last;
   assign fb_event  = fb_tick & main_last;

   prog_down_counter #(
      .W (`REF_W)
   ) u_ref_cnt (
      .clk_i    (CLK_I),
      .rst_i    (RST_I),
      .ce_i     (CE_I),
      .tick_i   (xtal_tick),
      .reload_i (ref_last),
      .value_i  (ref_latch),
      .count_o  (ref_count),
      .last_o   (ref_last),
      .zero_o   ()
   );

   prog_down_counter #(
      .W (`MAIN_W)
   ) u_main_cnt (
      .clk_i    (CLK_I),
      .rst_i    (RST_I),
      .ce_i     (CE_I),
      .tick_i   (fb_tick),
      .reload_i (main_last),
      .value_i  (main_value),
      .count_o  (main_count),
      .last_o   (main_last),
      .zero_o   ()
   );

   prog_down_counter #(
      .W (`SWAL_W)
   ) u_swal_cnt (
      .clk_i    (CLK_I),
      .rst_i    (RST_I),
      .ce_i     (CE_I),
      .tick_i   (fb_tick),
      .reload_i (main_last),
      .value_i  (swal_value),
      .count_o  (swal_count),
      .last_o   (swal_last),
      .zero_o   (swal_zero)
   );

   // Modulus for the prescaler output that follows this edge
   always @* begin
      if (main_last) begin
         next_mod = (swal_value == {`SWAL_W{1'b0}});
      end else begin
         next_mod = swal_last | swal_zero;
      end
   end

   // Modulus control moves on a feedback falling edge while running, and is forced high while stopped
   always @(posedge CLK_I) begin
      if (RST_I) begin
         MOD_CONTROL_O <= 1'b1;
      end else if (CE_I) begin
         if (!run) begin
            MOD_CONTROL_O <= 1'b1;
         end else if (fb_tick) begin
            MOD_CONTROL_O <= next_mod;
         end
      end
   end

   // Divided monitors and reference tap
   always @(posedge CLK_I) begin
      if (RST_I) begin
         REF_DIVIDED_OUT_O      <= 1'b0;
         FEEDBACK_DIVIDED_OUT_O <= 1'b0;
         REFERENCE_CLOCK_TAP_O  <= 1'b0;
      end else if (CE_I) begin
         REF_DIVIDED_OUT_O      <= run & ref_last;
         FEEDBACK_DIVIDED_OUT_O <= run & main_last;
         REFERENCE_CLOCK_TAP_O  <= pin_level[`PIN_XTAL];
      end
   end

   // Phase-frequency comparator; a lone new event wins over the mutual clear, coincident events clear both
   always @(posedge CLK_I) begin
      if (RST_I) begin
         PHASE_UP_O   <= 1'b0;
         PHASE_DOWN_O <= 1'b0;
      end else if (CE_I) begin
         if (!run) begin
            PHASE_UP_O   <= 1'b0;
            PHASE_DOWN_O <= 1'b0;
         end else if (ref_event && fb_event) begin
            PHASE_UP_O   <= 1'b0;
            PHASE_DOWN_O <= 1'b0;
         end else if (PHASE_UP_O && PHASE_DOWN_O) begin
            PHASE_UP_O   <= ref_event;
            PHASE_DOWN_O <= fb_event;
         end else begin
            PHASE_UP_O   <= PHASE_UP_O | ref_event;
            PHASE_DOWN_O <= PHASE_DOWN_O | fb_event;
         end
      end
   end

   // Lock output drops while either correction is active
   always @(posedge CLK_I) begin
      if (RST_I) begin
         LOCK_DETECT_O <= 1'b1;
      end else if (CE_I) begin
         LOCK_DETECT_O <= ~(PHASE_UP_O | PHASE_DOWN_O);
      end
   end

   // Wishbone slave, one wait state per access
   assign bus_req = CYC_I & STB_I & ~ACK_O;
   assign bus_wr  = bus_req & WE_I;
   assign status  = {shift_reg[`CTL_BIT], MOD_CONTROL_O, PHASE_DOWN_O,
                     PHASE_UP_O, LOCK_DETECT_O};

   always @(posedge CLK_I) begin
      if (RST_I) begin
         run <= `CTRL_RST;
      end else if (CE_I && bus_wr && SEL_I[0] &&
                   addr_hit(ADR_I, `OFF_CTRL)) begin
         run <= DAT_I[`CTRL_RUN];
      end
   end

   always @* begin
      next_dat = {`DATA_W{1'b0}};
      if (addr_hit(ADR_I, `OFF_CTRL)) begin
         next_dat[`CTRL_RUN] = run;
      end else if (addr_hit(ADR_I, `OFF_STATUS)) begin
         next_dat[`ST_W-1:0] = status;
      end else if (addr_hit(ADR_I, `OFF_REFLAT)) begin
         next_dat[`REF_W-1:0] = ref_latch;
      end else if (addr_hit(ADR_I, `OFF_DIVLAT)) begin
         next_dat[`DIV_W-1:0] = div_latch;
      end else if (addr_hit(ADR_I, `OFF_SHIFT)) begin
         next_dat[`SHIFT_W-1:0] = shift_reg;
      end
   end

   always @(posedge CLK_I) begin
      if (RST_I) begin
         ACK_O <= 1'b0;
         DAT_O <= {`DATA_W{1'b0}};
      end else if (CE_I) begin
         ACK_O <= bus_req;
         if (bus_req && !WE_I) begin
            DAT_O <= next_dat;
         end
      end
   end

endmodule
`default_nettype wire

// ==== sim/serial_pll_divider_programmer_asserts.sv ====
// Port checker for the serial divider programmer
// Assumes a bind to the top module with CE_I held high
`timescale 1ns/100ps
`default_nettype none
module serial_pll_divider_programmer_asserts (
   // System
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // Bus
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic WE_I,
   // Pins
   input wire logic CRYSTAL_INPUT_I,
   input wire logic FEEDBACK_IN_I,
   input wire logic MOD_CONTROL_O,
   input wire logic REF_DIVIDED_OUT_O,
   input wire logic FEEDBACK_DIVIDED_OUT_O,
   input wire logic REFERENCE_CLOCK_TAP_O,
   input wire logic LOCK_DETECT_O,
   input wire logic PHASE_UP_O,
   input wire logic PHASE_DOWN_O
);
   logic [2:0] since;
   logic [6:0] fbh;
   logic [6:0] xh;
   wire        fb_fell = |(fbh[6:1] & ~fbh[5:0]);
   wire        x_rose  = |(~xh[6:1] & xh[5:0]);
   always @(posedge CLK_I) begin
      fbh <= {fbh[5:0], FEEDBACK_IN_I};
      xh <= {xh[5:0], CRYSTAL_INPUT_I};
      if (RST_I || (ACK_O && WE_I))
         since <= 3'h0;
      else if (since != 3'h7)
         since <= since + 3'h1;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence bus_req;
      CYC_I && STB_I && !ACK_O && CE_I;
   endsequence
   sequence ack_pulse;
      ACK_O ##1 !ACK_O;
   endsequence
   chk_bus_answer: assert property (bus_req |=> ack_pulse)
      else $error("bus request not answered by one ack pulse");
   chk_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
      else $error("ack without request");
   chk_mod_on_fall: assert property (
      since == 3'h7 && $changed(MOD_CONTROL_O) |-> fb_fell)
      else $error("modulus changed away from feedback fall");
   chk_fbdiv_step: assert property (
      since == 3'h7 && $rose(FEEDBACK_DIVIDED_OUT_O) |-> fb_fell)
      else $error("feedback divided rise without feedback fall");
   chk_refdiv_step: assert property (
      since == 3'h7 && $rose(REF_DIVIDED_OUT_O) |-> x_rose)
      else $error("reference divided rise without crystal rise");
   chk_tap_follow: assert property (
      since == 3'h7 |-> REFERENCE_CLOCK_TAP_O == $past(CRYSTAL_INPUT_I, 3))
      else $error("reference tap does not follow crystal");
   chk_lock_quiet: assert property (
      (!PHASE_UP_O && !PHASE_DOWN_O)[*2] |-> LOCK_DETECT_O)
      else $error("lock low with no correction");
   chk_lock_active: assert property (
      (PHASE_UP_O || PHASE_DOWN_O)[*2] |-> !LOCK_DETECT_O)
      else $error("lock high during correction");
   chk_pfd_clear: assert property (
      PHASE_UP_O && PHASE_DOWN_O |=> !(PHASE_UP_O && PHASE_DOWN_O))
      else $error("up and down both held");
endmodule
bind serial_pll_divider_programmer serial_pll_divider_programmer_asserts
   chk_u (.*);
`default_nettype wire

// ==== sim/prescaler_model.sv ====
// Dual-modulus prescaler stand-in driving the feedback pin
// Assumes the modulus line settles well before each period ends
`timescale 1ns/100ps
`default_nettype none
module prescaler_model (
   // System
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Link
   input  wire logic mod_i,
   output wire logic fb_o
);
   logic [3:0] cnt;
   logic [3:0] len;
   assign fb_o = (cnt < 4'h3);
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 4'h0;
         len <= 4'hB;
      end else if (cnt >= len - 4'h1) begin
         cnt <= 4'h0;
         len <= mod_i ? 4'hB : 4'hC;
      end else
         cnt <= cnt + 4'h1;
   end
endmodule
`default_nettype wire

// ==== sim/serial_pll_divider_programmer_tb_top.sv ====
// Self-checking bench for the serial divider programmer
// Assumes the checker bind and the prescaler model file
`timescale 1ns/100ps
`default_nettype none
module serial_pll_divider_programmer_tb_top;
   logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic sck = 1'b0, sdat = 1'b0, le = 1'b0, xtal = 1'b0;
   logic [4:0] adr = 5'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [2:0] xc = 3'h0;
   logic [17:0] sh = 18'h0;
   logic ack, fb, mod, refdiv, fbdiv, lock, up, dn, xq, fq, rq, dq;
   logic [13:0] r;
   logic [9:0] n;
   logic [6:0] a;
   int seed, xr, fc, ml, last_r = -1, last_n = -1, last_a = -1;
   int miscompares = 0, total_checks = 0;
   logic [13:0] rt [2] = '{14'h5, 14'h9};
   logic [9:0] nt [2] = '{10'h5, 10'h7};
   logic [6:0] at [2] = '{7'h4, 7'h0};
   always #25 clk = ~clk;
   serial_pll_divider_programmer dut_u (.CLK_I(clk), .RST_I(rst),
      .CE_I(1'b1), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat),
      .SEL_I(4'hF), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
      .SER_CLOCK_I(sck), .SER_DATA_I(sdat), .LATCH_LOAD_STROBE_I(le),
      .CRYSTAL_INPUT_I(xtal), .FEEDBACK_IN_I(fb), .MOD_CONTROL_O(mod),
      .REF_DIVIDED_OUT_O(refdiv), .FEEDBACK_DIVIDED_OUT_O(fbdiv),
      .REFERENCE_CLOCK_TAP_O(), .LOCK_DETECT_O(lock),
      .PHASE_UP_O(up), .PHASE_DOWN_O(dn));
   prescaler_model pre_u (.clk_i(clk), .rst_i(rst), .mod_i(mod),
      .fb_o(fb));
   // Crystal at one eighth of the system clock, and period counters
   always @(posedge clk) begin
      xc <= xc + 3'h1;
      xtal <= xc[2];
      xq <= xtal;
      fq <= fb;
      rq <= refdiv;
      dq <= fbdiv;
      if (refdiv && !rq) begin
         last_r <= xr;
         xr <= int'(xtal && !xq);
      end else
         xr <= xr + int'(xtal && !xq);
      if (fbdiv && !dq) begin
         last_n <= fc;
         last_a <= ml;
         fc <= int'(fq && !fb);
         ml <= int'(fq && !fb && !mod);
      end else begin
         fc <= fc + int'(fq && !fb);
         ml <= ml + int'(fq && !fb && !mod);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [4:0] ad, input logic w,
                     input logic [31:0] d, output logic [31:0] res);
      int k;
      k = 0;
      @(posedge clk);
      adr <= ad;
      we <= w;
      wdat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      res = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50)
         chk(32'h0, 32'h1);
   endtask
   task automatic send(input logic [17:0] w, input int cnt);
      for (int i = cnt - 1; i >= 0; i--) begin
         sdat <= w[i];
         sh = {sh[16:0], w[i]};
         repeat (3) @(posedge clk);
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      le <= 1'b1;
      repeat (4) @(posedge clk);
      le <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic summarize;
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      summarize();
   end
   initial begin
      seed = 45;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wb(5'h00, 1'b0, 32'h0, q);
      chk(q, 32'h1);
      wb(5'h14, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      wb(5'h08, 1'b1, 32'hFFFF, q);
      wb(5'h08, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      for (int j = 0; j < 2; j++) begin
         send({3'h0, rt[j], 1'b1}, 15);
         send({nt[j], at[j], 1'b0}, 18);
         repeat (500) @(posedge clk);
         chk(32'(last_r), 32'(rt[j]));
         chk(32'(last_n), 32'(nt[j]));
         chk(32'(last_a), 32'(at[j]));
      end
      wb(5'h00, 1'b1, 32'h0, q);
      repeat (4) @(posedge clk);
      chk({29'h0, lock, up, dn}, 32'h4);
      wb(5'h00, 1'b1, 32'h1, q);
      for (int k = 0; k < 4; k++) begin
         r = 14'h5 + 14'($unsigned($random(seed)) % 16379);
         n = 10'h5 + 10'($unsigned($random(seed)) % 1019);
         a = 7'($random(seed));
         if (a >= n)
            a = 7'(n - 10'h1);
         if (k % 2 == 0)
            a[6] = 1'b0;
         send({3'h0, r, 1'b1}, 15);
         wb(5'h10, 1'b0, 32'h0, q);
         chk(q, {14'h0, sh});
         wb(5'h08, 1'b0, 32'h0, q);
         chk(q, {18'h0, r});
         send({n, a, 1'b0}, 18);
         wb(5'h0C, 1'b0, 32'h0, q);
         chk(q, {15'h0, n, a});
         wb(5'h08, 1'b0, 32'h0, q);
         chk(q, {18'h0, r});
      end
      summarize();
   end
endmodule
`default_nettype wire
